// [include/tbtc_pkg.sv]
package tbtc_pkg;
    localparam logic [11:0] TBTC_ADDR_EVEN_CTRL = 12'h000;
    localparam logic [11:0] TBTC_ADDR_ODD_CTRL = 12'h004;
    localparam logic [11:0] TBTC_ADDR_EVEN_CNT = 12'h008;
    localparam logic [11:0] TBTC_ADDR_ODD_CNT = 12'h00C;
    localparam logic [11:0] TBTC_ADDR_STATUS = 12'h010;
    localparam int TBTC_BIT_ON = 15;
    localparam int TBTC_BIT_IDLE = 13;
    localparam int TBTC_BIT_GATE = 7;
    localparam int TBTC_PS_LO = 4;
    localparam int TBTC_BIT_PAIR = 3;
    localparam int TBTC_BIT_SRC = 1;
    localparam logic [31:0] TBTC_EVEN_MASK = 32'h0000A0FA;
    localparam logic [31:0] TBTC_ODD_MASK = 32'h0000A0F2;
    localparam logic [31:0] TBTC_CTRL_RESET = 32'h00000000;
    localparam logic [2:0] TBTC_PS_MAX = 3'h7;

    typedef struct packed {
        logic on;
        logic idle_stop;
        logic gate_accumulate;
        logic [2:0] clock_prescale_select;
        logic pair_wide_mode;
        logic count_source_select;
    } tbtc_ctrl_t;

    typedef struct packed {
        logic idle_mode;
        logic ext_clk;
        logic gate_in;
    } tbtc_pins_t;
endpackage : tbtc_pkg

// [design/tbtc_prescaler.sv]
`timescale 1ns/10ps
module tbtc_prescaler #(
    parameter int WIDTH = 8
) (
    input wire logic pclk, // Bus clock
    input wire logic presetn, // Async reset, low
    input wire logic pce, // Clock enable
    input wire logic clr, // Restart the divider
    input wire logic tick_in, // Source event
    input wire logic [2:0] sel, // Prescale code
    output logic tick_out // Divided event
);
    typedef struct packed {
        logic [WIDTH-1:0] cnt;
    } tbtc_ps_state_t;

    tbtc_ps_state_t st_r;
    tbtc_ps_state_t st_nxt;
    logic [WIDTH-1:0] lim;

    // Refused at elaboration: 1:256 needs eight bits
    if (WIDTH < 8) begin : g_width_check
        $error("prescaler needs 8 bits for 1:256");
    end

    // Code 7 jumps to 256, not 128
    function automatic logic [WIDTH-1:0] ps_limit(input logic [2:0] s);
        logic [8:0] d;
        d = (s == tbtc_pkg::TBTC_PS_MAX) ? 9'h100 : (9'h001 << s);
        return WIDTH'(d - 9'h001);
    endfunction : ps_limit

    always_comb begin
        lim = ps_limit(sel);
        st_nxt = st_r;
        tick_out = tick_in && (st_r.cnt >= lim);
        if (clr) begin
            st_nxt.cnt = '0;
        end else if (tick_in) begin
            st_nxt.cnt = tick_out ? '0 : st_r.cnt + WIDTH'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
        end else if (pce) begin
            st_r <= st_nxt;
        end
    end
endmodule : tbtc_prescaler

// [design/tbtc_timer_pair.sv]
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/10ps
// What this block does
// - Timer counts only while enable bit set
// - Idle-stop bit halts timer in Idle
// - Gate bit ignored, reads zero, external source
// - Gate bit enables gated accumulation, internal source
// - Prescale codes divide 1,2,4,8,16,32,64,256
// - Pairing bit joins timers into 32 bits
// - Paired odd timer control bits ignored, except idle-stop
// - Pairing bit exists only in even timer
module tbtc_timer_pair #(
    parameter int PS_WIDTH = 8
) (
    input wire logic pclk, // Bus clock, 20 MHz
    input wire logic presetn, // Async reset, low
    input wire logic pce, // Clock enable
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire tbtc_pkg::tbtc_pins_t even_pins, // Even timer inputs
    input wire tbtc_pkg::tbtc_pins_t odd_pins, // Odd timer inputs
    output logic [15:0] even_count, // Even timer count
    output logic [15:0] odd_count // Odd timer count
);
    typedef struct packed {
        tbtc_pkg::tbtc_ctrl_t ev;
        tbtc_pkg::tbtc_ctrl_t od;
        logic [15:0] ev_cnt;
        logic [15:0] od_cnt;
        logic ev_ext_q;
        logic od_ext_q;
        logic [31:0] rdata;
        logic err;
    } tbtc_state_t;

    tbtc_state_t st_r;
    tbtc_state_t st_nxt;
    logic wr;
    logic rd;
    logic ev_run;
    logic od_run;
    logic ev_src;
    logic od_src;
    logic ev_tick;
    logic od_tick;
    logic ev_clr;
    logic od_clr;
    logic pair;

    function automatic logic [31:0] ctrl_pack(input tbtc_pkg::tbtc_ctrl_t c,
                                              input logic is_even);
        logic [31:0] w;
        w = '0;
        w[tbtc_pkg::TBTC_BIT_ON] = c.on;
        w[tbtc_pkg::TBTC_BIT_IDLE] = c.idle_stop;
        // Gate reads zero under external source
        w[tbtc_pkg::TBTC_BIT_GATE] = c.gate_accumulate &&
                                     !c.count_source_select;
        w[tbtc_pkg::TBTC_PS_LO +: 3] = c.clock_prescale_select;
        w[tbtc_pkg::TBTC_BIT_PAIR] = is_even && c.pair_wide_mode;
        w[tbtc_pkg::TBTC_BIT_SRC] = c.count_source_select;
        return w;
    endfunction : ctrl_pack

    function automatic tbtc_pkg::tbtc_ctrl_t ctrl_unpack(
            input logic [31:0] w, input logic is_even);
        tbtc_pkg::tbtc_ctrl_t c;
        c.on = w[tbtc_pkg::TBTC_BIT_ON];
        c.idle_stop = w[tbtc_pkg::TBTC_BIT_IDLE];
        c.gate_accumulate = w[tbtc_pkg::TBTC_BIT_GATE];
        c.clock_prescale_select = w[tbtc_pkg::TBTC_PS_LO +: 3];
        c.pair_wide_mode = is_even && w[tbtc_pkg::TBTC_BIT_PAIR];
        c.count_source_select = w[tbtc_pkg::TBTC_BIT_SRC];
        return c;
    endfunction : ctrl_unpack

    // Run qualification: enable, idle stop, gating
    function automatic logic run_ok(input tbtc_pkg::tbtc_ctrl_t c,
                                    input tbtc_pkg::tbtc_pins_t p);
        logic gated;
        gated = c.gate_accumulate && !c.count_source_select;
        return c.on
            && !(c.idle_stop && p.idle_mode)
            && (!gated || p.gate_in);
    endfunction : run_ok

    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;
    assign pair = st_r.ev.pair_wide_mode;
    assign pready = 1'b1;
    assign prdata = st_r.rdata;
    assign pslverr = psel && penable && st_r.err;
    assign even_count = st_r.ev_cnt;
    assign odd_count = st_r.od_cnt;

    // Paired: even controls govern; odd idle-stop still gates
    assign ev_run = run_ok(st_r.ev, even_pins) &&
                    !(pair && st_r.od.idle_stop &&
                      even_pins.idle_mode);
    assign od_run = run_ok(st_r.od, odd_pins);
    // External clock rising edge, synchronous input
    assign ev_src = st_r.ev.count_source_select ?
                    (even_pins.ext_clk && !st_r.ev_ext_q) : 1'b1;
    assign od_src = st_r.od.count_source_select ?
                    (odd_pins.ext_clk && !st_r.od_ext_q) : 1'b1;
    assign ev_clr = !st_r.ev.on;
    assign od_clr = !st_r.od.on || pair;

    tbtc_prescaler #(.WIDTH(PS_WIDTH)) u_ps_even (
        .pclk(pclk),
        .presetn(presetn),
        .pce(pce),
        .clr(ev_clr),
        .tick_in(ev_src && ev_run),
        .sel(st_r.ev.clock_prescale_select),
        .tick_out(ev_tick)
    );

    tbtc_prescaler #(.WIDTH(PS_WIDTH)) u_ps_odd (
        .pclk(pclk),
        .presetn(presetn),
        .pce(pce),
        .clr(od_clr),
        .tick_in(od_src && od_run),
        .sel(st_r.od.clock_prescale_select),
        .tick_out(od_tick)
    );

    always_comb begin
        st_nxt = st_r;
        st_nxt.ev_ext_q = even_pins.ext_clk;
        st_nxt.od_ext_q = odd_pins.ext_clk;
        if (pair) begin
            if (ev_tick) begin
                {st_nxt.od_cnt, st_nxt.ev_cnt} =
                    {st_r.od_cnt, st_r.ev_cnt} + 32'h00000001;
            end
        end else begin
            if (ev_tick) st_nxt.ev_cnt = st_r.ev_cnt + 16'h0001;
            if (od_tick && !pair) st_nxt.od_cnt = st_r.od_cnt + 16'h0001;
        end
        if (rd) begin
            st_nxt.err = 1'b0;
            unique case (paddr)
                tbtc_pkg::TBTC_ADDR_EVEN_CTRL:
                    st_nxt.rdata = ctrl_pack(st_r.ev, 1'b1);
                tbtc_pkg::TBTC_ADDR_ODD_CTRL:
                    st_nxt.rdata = ctrl_pack(st_r.od, 1'b0);
                tbtc_pkg::TBTC_ADDR_EVEN_CNT:
                    st_nxt.rdata = {16'h0000, st_r.ev_cnt};
                tbtc_pkg::TBTC_ADDR_ODD_CNT:
                    st_nxt.rdata = {16'h0000, st_r.od_cnt};
                tbtc_pkg::TBTC_ADDR_STATUS:
                    st_nxt.rdata = {29'h00000000, pair, od_run, ev_run};
                default: begin
                    st_nxt.rdata = 32'h00000000;
                    st_nxt.err = 1'b1;
                end
            endcase
        end else if (psel && !penable) begin
            st_nxt.rdata = 32'h00000000;
            st_nxt.err = !(paddr == tbtc_pkg::TBTC_ADDR_EVEN_CTRL ||
                           paddr == tbtc_pkg::TBTC_ADDR_ODD_CTRL ||
                           paddr == tbtc_pkg::TBTC_ADDR_EVEN_CNT ||
                           paddr == tbtc_pkg::TBTC_ADDR_ODD_CNT);
        end
        if (wr && !st_r.err) begin
            unique case (paddr)
                tbtc_pkg::TBTC_ADDR_EVEN_CTRL:
                    st_nxt.ev = ctrl_unpack(pwdata &
                        tbtc_pkg::TBTC_EVEN_MASK, 1'b1);
                tbtc_pkg::TBTC_ADDR_ODD_CTRL:
                    st_nxt.od = ctrl_unpack(pwdata &
                        tbtc_pkg::TBTC_ODD_MASK, 1'b0);
                tbtc_pkg::TBTC_ADDR_EVEN_CNT:
                    st_nxt.ev_cnt = pwdata[15:0];
                tbtc_pkg::TBTC_ADDR_ODD_CNT:
                    st_nxt.od_cnt = pwdata[15:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
        end else if (pce) begin
            st_r <= st_nxt;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_off_holds: assert property (pce && !st_r.ev.on && !pair && !wr
        |=> st_r.ev_cnt == $past(st_r.ev_cnt))
        else $error("even timer moved while disabled");
    chk_idle_stop: assert property (pce && st_r.ev.idle_stop &&
        even_pins.idle_mode |-> !ev_run)
        else $error("even timer ran in idle with stop");
    chk_gate_reads: assert property (rd &&
        paddr == tbtc_pkg::TBTC_ADDR_EVEN_CTRL &&
        st_r.ev.count_source_select && pce
        |=> !prdata[tbtc_pkg::TBTC_BIT_GATE])
        else $error("gate bit read as one");
    chk_gate_low: assert property (st_r.ev.on &&
        st_r.ev.gate_accumulate && !st_r.ev.count_source_select &&
        !even_pins.gate_in |-> !ev_run)
        else $error("gated timer ran with gate low");
    chk_ps_one: assert property (pce && ev_run && !pair &&
        st_r.ev.clock_prescale_select == 3'h0 &&
        !st_r.ev.count_source_select && !wr
        |=> st_r.ev_cnt == $past(st_r.ev_cnt) + 16'h0001)
        else $error("1:1 prescale missed a count");
    chk_pair_carry: assert property (pce && pair && ev_tick &&
        st_r.ev_cnt == 16'hFFFF && !wr
        |=> st_r.od_cnt == $past(st_r.od_cnt) + 16'h0001)
        else $error("pair carry lost");
    chk_odd_frozen: assert property (pce && pair && !wr
        && st_r.ev_cnt != 16'hFFFF
        |=> st_r.od_cnt == $past(st_r.od_cnt))
        else $error("odd half moved on its own");
    chk_odd_nopair: assert property (rd &&
        paddr == tbtc_pkg::TBTC_ADDR_ODD_CTRL && pce
        |=> !prdata[tbtc_pkg::TBTC_BIT_PAIR])
        else $error("odd pairing bit read as one");
    chk_ext_src: assert property (st_r.ev.count_source_select &&
        !even_pins.ext_clk |-> !ev_tick)
        else $error("external source counted without edge");

    cov_pair: cover property (pce && pair && ev_tick);
    cov_gated: cover property (ev_run && st_r.ev.gate_accumulate);
    cov_ps256: cover property (ev_tick &&
        st_r.ev.clock_prescale_select == 3'h7);
endmodule : tbtc_timer_pair

// [testbench/testbench.sv]
`timescale 1ns/10ps
module testbench;
    localparam logic [31:0] ON = 32'h00008000;
    localparam logic [31:0] IDL = 32'h00002000;
    localparam logic [31:0] GT = 32'h00000080;
    localparam logic [31:0] PR = 32'h00000008;
    localparam logic [31:0] SRC = 32'h00000002;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic pce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    tbtc_pkg::tbtc_pins_t ev = '0;
    tbtc_pkg::tbtc_pins_t od = '0;
    logic [15:0] even_count;
    logic [15:0] odd_count;
    logic [31:0] q;
    logic [31:0] w;
    logic e;
    logic [15:0] ce;
    logic [15:0] co;
    int err_total = 0;
    int n_tests = 0;
    int cyc = 0;
    int n;

    tbtc_timer_pair dut (.pclk(pclk), .presetn(presetn), .pce(pce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .even_pins(ev), .odd_pins(od),
        .even_count(even_count), .odd_count(odd_count));

    always #25 pclk = ~pclk;

    task print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict

    // Ceiling well above the few thousand cycles the tests need
    always @(posedge pclk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            err_total = err_total + 1;
            print_verdict();
        end
    end

    task check(input string nm, input logic [31:0] s, input logic [31:0] x);
        n_tests = n_tests + 1;
        if (s !== x) begin
            err_total = err_total + 1;
            $display("[FAIL] %s expected %h seen %h", nm, x, s);
        end
    endtask : check

    // Start and stop edges shift the tick count by a cycle or two
    task near(input string nm, input logic [15:0] s, input int x, input int t);
        check(nm, {31'h0, (int'(s) >= x - t) && (int'(s) <= x + t)}, 32'h1);
    endtask : near

    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Ends once pready is high, which is tied high; the bench timeout catches a stall
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task start(input logic [31:0] c, input logic [15:0] s);
        apb(1'b1, tbtc_pkg::TBTC_ADDR_EVEN_CNT, {16'h0, s});
        apb(1'b1, tbtc_pkg::TBTC_ADDR_ODD_CNT, 32'h0);
        apb(1'b1, tbtc_pkg::TBTC_ADDR_EVEN_CTRL, c);
    endtask : start

    task stop(input logic [31:0] c);
        apb(1'b1, tbtc_pkg::TBTC_ADDR_EVEN_CTRL, c & ~ON);
        apb(1'b0, tbtc_pkg::TBTC_ADDR_EVEN_CNT, 32'h0);
        ce = q[15:0];
        apb(1'b0, tbtc_pkg::TBTC_ADDR_ODD_CNT, 32'h0);
        co = q[15:0];
    endtask : stop

    function automatic logic [31:0] ctrl_exp(input logic [31:0] v,
                                             input bit even);
        logic [31:0] m;
        m = v & (even ? tbtc_pkg::TBTC_EVEN_MASK : tbtc_pkg::TBTC_ODD_MASK);
        if (m[tbtc_pkg::TBTC_BIT_SRC]) m[tbtc_pkg::TBTC_BIT_GATE] = 1'b0;
        return m;
    endfunction : ctrl_exp

    initial begin
        void'($urandom(32'h10aeb845));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, tbtc_pkg::TBTC_ADDR_EVEN_CTRL, 32'h0);
        check("even ctrl reset", q, tbtc_pkg::TBTC_CTRL_RESET);
        apb(1'b0, tbtc_pkg::TBTC_ADDR_ODD_CTRL, 32'h0);
        check("odd ctrl reset", q, tbtc_pkg::TBTC_CTRL_RESET);
        for (int i = 0; i < 8; i++) begin
            w = $urandom();
            if (i == 0) w = 32'hFFFFFFFF;
            if (i == 1) w = 32'h0000FFFD;
            apb(1'b1, tbtc_pkg::TBTC_ADDR_EVEN_CTRL, w);
            apb(1'b0, tbtc_pkg::TBTC_ADDR_EVEN_CTRL, 32'h0);
            check("even ctrl", q, ctrl_exp(w, 1'b1));
            apb(1'b1, tbtc_pkg::TBTC_ADDR_ODD_CTRL, w);
            apb(1'b0, tbtc_pkg::TBTC_ADDR_ODD_CTRL, 32'h0);
            check("odd ctrl", q, ctrl_exp(w, 1'b0));
        end
        apb(1'b0, 12'h020, 32'h0);
        check("unmapped error", {31'h0, e}, 32'h1);
        check("unmapped data", q, 32'h0);
        apb(1'b1, tbtc_pkg::TBTC_ADDR_ODD_CTRL, 32'h0);
        // Random controls above may leave the even timer running
        apb(1'b1, tbtc_pkg::TBTC_ADDR_EVEN_CTRL, 32'h0);
        for (int c = 0; c < 8; c++) begin
            n = (c == 7) ? 256 : (1 << c);
            start(ON | (c << tbtc_pkg::TBTC_PS_LO), 16'h0);
            repeat (4 * n) @(posedge pclk);
            stop(ON | (c << tbtc_pkg::TBTC_PS_LO));
            near("prescaled count", ce, (4 * n + 2) / n, 2);
        end
        start(32'h0, 16'h0);
        repeat (20) @(posedge pclk);
        stop(32'h0);
        check("count while off", {16'h0, ce}, 32'h0);
        check("even count pin", {16'h0, even_count}, 32'h0);
        ev.idle_mode <= 1'b1;
        start(ON | IDL, 16'h0);
        repeat (20) @(posedge pclk);
        stop(IDL);
        check("count idle stopped", {16'h0, ce}, 32'h0);
        start(ON, 16'h0);
        repeat (20) @(posedge pclk);
        stop(32'h0);
        near("count idle running", ce, 22, 2);
        ev.idle_mode <= 1'b0;
        start(ON | GT, 16'h0);
        repeat (20) @(posedge pclk);
        stop(GT);
        check("gate low count", {16'h0, ce}, 32'h0);
        ev.gate_in <= 1'b1;
        start(ON | GT, 16'h0);
        repeat (20) @(posedge pclk);
        stop(GT);
        near("gate high count", ce, 22, 2);
        ev.gate_in <= 1'b0;
        // Gate low and gate bit set: only an ignored gate lets edges count
        n = 3 + $urandom_range(5);
        start(ON | SRC | GT, 16'h0);
        repeat (n) begin
            @(posedge pclk) ev.ext_clk <= 1'b1;
            repeat (3) @(posedge pclk);
            ev.ext_clk <= 1'b0;
            repeat (3) @(posedge pclk);
        end
        stop(SRC | GT);
        near("external edges", ce, n, 1);
        for (int p = 0; p < 2; p++) begin
            // Odd timer switched on: must not matter when paired
            apb(1'b1, tbtc_pkg::TBTC_ADDR_ODD_CTRL, ON | SRC | 32'h00000070);
            start(ON | (p ? PR : 32'h0), 16'hFFF0);
            apb(1'b0, tbtc_pkg::TBTC_ADDR_STATUS, 32'h0);
            check("status", q, p ? 32'h00000007 : 32'h00000003);
            repeat (37) @(posedge pclk);
            stop(p ? PR : 32'h0);
            near("low half wrap", ce, 26, 2);
            check("high half carry", {16'h0, co}, p);
            check("odd count pin", {16'h0, odd_count}, p);
        end
        // Paired timer in Idle: odd idle-stop must be cleared to run
        ev.idle_mode <= 1'b1;
        for (int s = 0; s < 2; s++) begin
            apb(1'b1, tbtc_pkg::TBTC_ADDR_ODD_CTRL, s ? 32'h0 : IDL);
            start(ON | PR, 16'h0);
            repeat (20) @(posedge pclk);
            stop(PR);
            near("paired idle count", ce, s ? 22 : 0, s ? 2 : 0);
        end
        ev.idle_mode <= 1'b0;
        // Clock enable low freezes the count: 5 + 5 + 3 ticks
        start(ON, 16'h0);
        repeat (5) @(posedge pclk);
        pce <= 1'b0;
        repeat (30) @(posedge pclk);
        pce <= 1'b1;
        repeat (5) @(posedge pclk);
        stop(32'h0);
        near("count with pce low", ce, 13, 1);
        print_verdict();
    end
endmodule : testbench
